/* File: rtl/usb_ep_pkg.sv */
// Constants and types shared by the endpoint control register block
package usb_ep_pkg;

    // ********************************************************************
    // Register indices (byte address is four times the index)
    // ********************************************************************
    localparam logic [5:0] IDX_FLAGS0 = 6'h18;  // First flag bank, mirror
    localparam logic [5:0] IDX_FLAGS1 = 6'h1A;  // Second flag bank
    localparam logic [5:0] IDX_TRIG   = 6'h1C;  // One-shot triggers
    localparam logic [5:0] IDX_CLEAR  = 6'h1E;  // Buffer clear
    localparam logic [5:0] IDX_SZ0    = 6'h20;  // Endpoint 0 out size
    localparam logic [5:0] IDX_DPRES  = 6'h22;  // Transmit data present
    localparam logic [5:0] IDX_HALT   = 6'h24;  // Endpoint halt
    localparam logic [5:0] IDX_IEN0   = 6'h26;  // Enable, first bank
    localparam logic [5:0] IDX_IEN1   = 6'h28;  // Enable, second bank
    localparam logic [5:0] IDX_SZ1    = 6'h2A;  // Endpoint 1 size
    localparam logic [5:0] IDX_VSEL0  = 6'h2E;  // Vector select, bank 0
    localparam logic [5:0] IDX_VSEL1  = 6'h30;  // Vector select, bank 1

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int B_EP0I     = 0;  // Endpoint 0 in (trigger/clear/present)
    localparam int B_EP0O     = 1;  // Endpoint 0 out
    localparam int B_SETUP    = 2;  // Setup read done trigger
    localparam int B_EP2      = 4;  // Endpoint 2 transmit
    localparam int B_EP1      = 5;  // Endpoint 1 receive
    localparam int B_EP3      = 6;  // Endpoint 3 transmit
    localparam int B_P_EP3    = 5;  // Data present, endpoint 3
    localparam int B_F1_VBUS  = 0;  // Bus connect flag
    localparam int B_F1_SENT  = 1;  // Endpoint 3 sent flag
    localparam int B_F1_REQ   = 2;  // Endpoint 3 request flag
    localparam int B_F0_SETUP = 3;  // Setup received flag in bank 0

    // ********************************************************************
    // Masks and reset values
    // ********************************************************************
    localparam logic [7:0] TRIG_MASK  = 8'h77;
    localparam logic [7:0] CLEAR_MASK = 8'h73;
    localparam logic [7:0] FLAG1_MASK = 8'h07;
    localparam logic [7:0] HALT_MASK  = 8'h0F;
    localparam logic [7:0] VSEL0_RST  = 8'h00;
    localparam logic [7:0] VSEL1_RST  = 8'h07;
    localparam logic [1:0] EP2_SLOTS  = 2'h2;  // Dual transmit buffer

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic       ep3_in_token;  // IN token for endpoint 3
        logic       ep3_tx_acked;  // Endpoint 3 packet acknowledged
        logic       ep2_tx_done;   // Endpoint 2 packet fully sent
        logic       ep0i_tx_done;  // Endpoint 0 in packet fully sent
        logic       setup_rx;      // Setup command for software received
        logic       cmd_decoded;   // Command decoded inside the function
        logic       ep0o_rx_done;  // Endpoint 0 out packet received
        logic       ep1_rx_done;   // Endpoint 1 packet received
        logic [7:0] rx_count;      // Byte count of received packet
    } usb_evt_t;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdat;
        logic [7:0] trig;
        logic [7:0] flush;
        logic [7:0] ien0;
        logic [7:0] ien1;
        logic [7:0] vsel0;
        logic [7:0] vsel1;
        logic [3:0] halt;
        logic [7:0] sz0;
        logic [7:0] dpres;
        logic [1:0] ep2_cnt;
        logic       setup_hold;
        logic       vbus_q;
        logic       ep3_nak;
        logic       irq_a;
        logic       irq_b;
    } ctl_state_t;

    typedef struct packed {
        logic [7:0] flags;
    } flag_state_t;

    typedef struct packed {
        logic [1:0][7:0] mem;
        logic            wp;
        logic            rp;
        logic [7:0]      rdat;
    } size_state_t;

    // Register select from a byte address
    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [5:0] idx);
        return adr[7:2] == idx;
    endfunction

endpackage

/* File: rtl/usb_flag_bank.sv */
// Sticky flag bank cleared by writing zero to a flag position
`timescale 1ns/100ps
`default_nettype none
module usb_flag_bank #(
    parameter logic [7:0] MASK = 8'hFF
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] set_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    output var  logic [7:0] flags_o
);

    usb_ep_pkg::flag_state_t st_ff;   // Registered flags
    usb_ep_pkg::flag_state_t nxt_st;  // Next flags

    // ********************************************************************
    // Per-bit update; a set in the clearing cycle wins
    // ********************************************************************
    for (genvar i = 0; i < 8; i++) begin : g_bit
        always_comb begin
            nxt_st.flags[i] = MASK[i] & (set_i[i] |
                (st_ff.flags[i] & ~(wr_i & ~wdata_i[i])));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flags_o = st_ff.flags;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    set_wins_a: assert property ((set_i & MASK) != 8'h00 |=>
        (flags_o & $past(set_i & MASK)) == $past(set_i & MASK))
        else $error("flag set lost");
    keep_ones_a: assert property (wr_i && set_i == 8'h00 |=>
        flags_o == ($past(flags_o) & $past(wdata_i)))
        else $error("flag clear wrong");

endmodule
`default_nettype wire

/* File: rtl/usb_size_bank.sv */
// Two-entry receive size memory for the dual endpoint 1 buffer
`timescale 1ns/100ps
`default_nettype none
module usb_size_bank (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       flush_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       done_i,
    output var  logic [7:0] rdata_o
);

    usb_ep_pkg::size_state_t st_ff;   // Memory and pointers
    usb_ep_pkg::size_state_t nxt_st;  // Next state

    // ********************************************************************
    // Fill one half, read the other; read done frees the read half
    // ********************************************************************
    always_comb begin
        nxt_st = st_ff;
        if (wr_i) begin
            nxt_st.mem[st_ff.wp] = wdata_i;
            nxt_st.wp = ~st_ff.wp;
        end
        if (done_i) begin
            nxt_st.rp = ~st_ff.rp;
        end
        if (flush_i) begin
            nxt_st.wp = 1'b0;       // Both halves dropped
            nxt_st.rp = 1'b0;
            nxt_st.mem = '0;
        end
        nxt_st.rdat = nxt_st.mem[nxt_st.rp];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdat;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    half_swap_a: assert property (done_i && !flush_i |=>
        st_ff.rp != $past(st_ff.rp))
        else $error("read half not released");

endmodule
`default_nettype wire

/* File: rtl/usb_ep_ctrl.sv */
// Endpoint sequencing, status and interrupt registers on Wishbone
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Second-bank events set flag; enabled raises interrupt
// - Write zero clears flag; ones keep others
// - Endpoint 3 IN without data: flag, NAK
// - Endpoint 3 acknowledged packet sets sent flag
// - Rising bus power edge sets connect flag
// - Trigger bits write-only, one pulse each
// - Trigger bit 6 commits endpoint 3 packet
// - Trigger bit 5 frees read endpoint 1 half
// - Trigger bit 4 commits endpoint 2 packet
// - Data stage NAKed until trigger bit 2
// - Trigger bit 1 frees endpoint 0 receive
// - Trigger bit 0 commits endpoint 0 packet
// - Buffer clear discards data, keeps flags
// - Clear bits 6,5,4,1,0 map to buffers
// - Endpoint 0 receive size holds last count
// - Data present set on commit, cleared sent
// - Halt bits make endpoints answer STALL
// - Decoded command clears endpoint 0 halt
// - Setup flag set blocks endpoint 0 halt
// - Enable bits gate flags onto interrupts
// - Endpoint 1 size follows selected half
// - Select zero routes line a, one b
// - Endpoints 1 and 2 dual buffer; others single packet
module usb_ep_ctrl (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire usb_ep_pkg::wb_req_t  wb_i,
    output var  logic [31:0]          wb_dat_o,
    output var  logic                 wb_ack_o,
    input  wire usb_ep_pkg::usb_evt_t evt_i,
    input  wire logic [7:0]           interrupt_flags_bank0_i,
    input  wire logic                 vbus_i,
    output var  logic [7:0]           trig_o,
    output var  logic [7:0]           flush_o,
    output var  logic [3:0]           halt_o,
    output var  logic                 ep3_nak_o,
    output var  logic                 data_stage_nak_o,
    output var  logic                 usb_irq_line_a_o,
    output var  logic                 usb_irq_line_b_o
);

    // ********************************************************************
    // State and bus decode
    // ********************************************************************
    usb_ep_pkg::ctl_state_t st_ff;   // State except the second flag bank and endpoint 1 sizes
    usb_ep_pkg::ctl_state_t nxt_st;  // Next block state

    logic       req;          // New bus request, not yet answered
    logic       wr;           // Write taken this cycle
    logic [7:0] wd;           // Write data, low lane
    logic [7:0] flags1;       // Second flag bank
    logic [7:0] set1;         // Second-bank event sources
    logic [7:0] ep1_size;     // Size of selected endpoint 1 half
    logic [7:0] pend_a;       // Pending requests routed to line a
    logic [7:0] pend_b;       // Pending requests routed to line b
    logic [7:0] flags0;       // Short name for the first bank

    // Answer one cycle after the request; ack drops again afterward
    assign req = wb_i.cyc & wb_i.stb & ~st_ff.ack;
    // Byte registers sit in lane 0; other lanes are ignored
    assign wr = req & wb_i.we & wb_i.sel[0];
    assign wd = wb_i.dat[7:0];
    assign flags0 = interrupt_flags_bank0_i;

    // ********************************************************************
    // Second flag bank
    // ********************************************************************
    // Events are single-cycle pulses from the packet engine
    always_comb begin
        set1 = 8'h00;
        // Only a rising edge counts; a held level sets once
        set1[usb_ep_pkg::B_F1_VBUS] = vbus_i & ~st_ff.vbus_q;
        set1[usb_ep_pkg::B_F1_SENT] = evt_i.ep3_tx_acked;
        set1[usb_ep_pkg::B_F1_REQ]  = evt_i.ep3_in_token &
            ~st_ff.dpres[usb_ep_pkg::B_P_EP3];
    end

    usb_flag_bank #(
        .MASK (usb_ep_pkg::FLAG1_MASK)
    ) u_flags1 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (set1),
        .wr_i    (wr & usb_ep_pkg::reg_hit(wb_i.adr,
                                           usb_ep_pkg::IDX_FLAGS1)),
        .wdata_i (wd),
        .flags_o (flags1)
    );

    // ********************************************************************
    // Endpoint 1 receive sizes
    // ********************************************************************
    // Read pointer moves on the read-done pulse, one cycle after write
    usb_size_bank u_ep1_size (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .flush_i (st_ff.flush[usb_ep_pkg::B_EP1]),
        .wr_i    (evt_i.ep1_rx_done),
        .wdata_i (evt_i.rx_count),
        .done_i  (st_ff.trig[usb_ep_pkg::B_EP1]),
        .rdata_o (ep1_size)
    );

    // ********************************************************************
    // Interrupt routing
    // ********************************************************************
    // Enabled flags, split by the vector select bits
    always_comb begin
        pend_a = (flags0 & st_ff.ien0 & ~st_ff.vsel0) |
                 (flags1 & st_ff.ien1 & ~st_ff.vsel1);
        pend_b = (flags0 & st_ff.ien0 & st_ff.vsel0) |
                 (flags1 & st_ff.ien1 & st_ff.vsel1);
    end

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req;
        nxt_st.vbus_q = vbus_i;

        // Triggers and clears are pulses, never stored
        nxt_st.trig = 8'h00;
        nxt_st.flush = 8'h00;

        // Read data captured with the answer; writes read zero
        if (req) begin
            if (wb_i.we) begin
                nxt_st.rdat = 8'h00;
            end else begin
                case (wb_i.adr[7:2])
                    usb_ep_pkg::IDX_FLAGS0: nxt_st.rdat = flags0;
                    usb_ep_pkg::IDX_FLAGS1: nxt_st.rdat = flags1;
                    usb_ep_pkg::IDX_SZ0:    nxt_st.rdat = st_ff.sz0;
                    usb_ep_pkg::IDX_DPRES:  nxt_st.rdat = st_ff.dpres;
                    usb_ep_pkg::IDX_HALT:   nxt_st.rdat = {4'h0, st_ff.halt};
                    usb_ep_pkg::IDX_IEN0:   nxt_st.rdat = st_ff.ien0;
                    usb_ep_pkg::IDX_IEN1:   nxt_st.rdat = st_ff.ien1;
                    usb_ep_pkg::IDX_SZ1:    nxt_st.rdat = ep1_size;
                    usb_ep_pkg::IDX_VSEL0:  nxt_st.rdat = st_ff.vsel0;
                    usb_ep_pkg::IDX_VSEL1:  nxt_st.rdat = st_ff.vsel1;
                    // Trigger, clear and unmapped words read zero
                    default:                nxt_st.rdat = 8'h00;
                endcase
            end
        end

        // Register writes
        if (wr) begin
            // One pulse per written one in bits 6-4 and 2-0
            if (usb_ep_pkg::reg_hit(wb_i.adr, usb_ep_pkg::IDX_TRIG)) begin
                nxt_st.trig = wd & usb_ep_pkg::TRIG_MASK;
            end
            // Writing zero has no effect
            if (usb_ep_pkg::reg_hit(wb_i.adr, usb_ep_pkg::IDX_CLEAR)) begin
                nxt_st.flush = wd & usb_ep_pkg::CLEAR_MASK;
            end
            if (usb_ep_pkg::reg_hit(wb_i.adr, usb_ep_pkg::IDX_IEN0)) begin
                nxt_st.ien0 = wd;
            end
            if (usb_ep_pkg::reg_hit(wb_i.adr, usb_ep_pkg::IDX_IEN1)) begin
                nxt_st.ien1 = wd & usb_ep_pkg::FLAG1_MASK;
            end
            if (usb_ep_pkg::reg_hit(wb_i.adr, usb_ep_pkg::IDX_VSEL0)) begin
                nxt_st.vsel0 = wd;
            end
            if (usb_ep_pkg::reg_hit(wb_i.adr, usb_ep_pkg::IDX_VSEL1)) begin
                nxt_st.vsel1 = wd & usb_ep_pkg::FLAG1_MASK;
            end
            if (usb_ep_pkg::reg_hit(wb_i.adr, usb_ep_pkg::IDX_HALT)) begin
                nxt_st.halt = wd[3:0];
                // Pending setup: a one cannot arm endpoint 0 halt
                if (flags0[usb_ep_pkg::B_F0_SETUP]) begin
                    nxt_st.halt[0] = wd[0] & st_ff.halt[0];
                end
            end
        end

        // Function-decoded command always wins over a write
        if (evt_i.cmd_decoded) begin
            nxt_st.halt[0] = 1'b0;
        end

        // Endpoint 0 out receive size
        if (evt_i.ep0o_rx_done) begin
            nxt_st.sz0 = evt_i.rx_count;
        end
        if (st_ff.flush[usb_ep_pkg::B_EP0O]) begin
            nxt_st.sz0 = 8'h00;
        end

        // Endpoint 0 in: single packet present flag
        if (evt_i.ep0i_tx_done) begin
            nxt_st.dpres[usb_ep_pkg::B_EP0I] = 1'b0;
        end
        if (st_ff.trig[usb_ep_pkg::B_EP0I]) begin
            nxt_st.dpres[usb_ep_pkg::B_EP0I] = 1'b1;
        end
        if (st_ff.flush[usb_ep_pkg::B_EP0I]) begin
            nxt_st.dpres[usb_ep_pkg::B_EP0I] = 1'b0;
        end

        // Endpoint 3: single 8-byte packet, one present bit
        if (evt_i.ep3_tx_acked) begin
            nxt_st.dpres[usb_ep_pkg::B_P_EP3] = 1'b0;
        end
        if (st_ff.trig[usb_ep_pkg::B_EP3]) begin
            nxt_st.dpres[usb_ep_pkg::B_P_EP3] = 1'b1;
        end
        if (st_ff.flush[usb_ep_pkg::B_EP3]) begin
            nxt_st.dpres[usb_ep_pkg::B_P_EP3] = 1'b0;
        end

        // Endpoint 2: count of committed halves, saturates at two
        // Extra commits beyond two are dropped: software overran buffer
        if (st_ff.trig[usb_ep_pkg::B_EP2] && !evt_i.ep2_tx_done &&
            st_ff.ep2_cnt != usb_ep_pkg::EP2_SLOTS) begin
            nxt_st.ep2_cnt = st_ff.ep2_cnt + 2'h1;
        end else if (evt_i.ep2_tx_done && !st_ff.trig[usb_ep_pkg::B_EP2]
                     && st_ff.ep2_cnt != 2'h0) begin
            nxt_st.ep2_cnt = st_ff.ep2_cnt - 2'h1;
        end
        if (st_ff.flush[usb_ep_pkg::B_EP2]) begin
            nxt_st.ep2_cnt = 2'h0;
        end
        nxt_st.dpres[usb_ep_pkg::B_EP2] = nxt_st.ep2_cnt != 2'h0;

        // Data stage held off until setup buffer is read
        if (st_ff.trig[usb_ep_pkg::B_SETUP]) begin
            nxt_st.setup_hold = 1'b0;
        end
        if (evt_i.setup_rx) begin
            nxt_st.setup_hold = 1'b1;
        end

        // Endpoint 3 answers NAK while nothing is committed
        nxt_st.ep3_nak = evt_i.ep3_in_token &
            ~st_ff.dpres[usb_ep_pkg::B_P_EP3];

        // Interrupt lines registered for clean outputs
        nxt_st.irq_a = |pend_a;
        nxt_st.irq_b = |pend_b;
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.vsel0 <= usb_ep_pkg::VSEL0_RST;
            st_ff.vsel1 <= usb_ep_pkg::VSEL1_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ********************************************************************
    // Outputs, all straight from flops
    // ********************************************************************
    assign wb_dat_o = {24'h000000, st_ff.rdat};
    assign wb_ack_o = st_ff.ack;
    assign trig_o = st_ff.trig;            // Bit 1 frees ep0 out
    assign flush_o = st_ff.flush;
    assign halt_o = st_ff.halt;
    assign ep3_nak_o = st_ff.ep3_nak;
    assign data_stage_nak_o = st_ff.setup_hold;
    assign usb_irq_line_a_o = st_ff.irq_a;
    assign usb_irq_line_b_o = st_ff.irq_b;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence trig_wr(int b);
        wr && usb_ep_pkg::reg_hit(wb_i.adr, usb_ep_pkg::IDX_TRIG) && wd[b];
    endsequence

    sequence one_pulse(int b);
        trig_o[b] ##1 !trig_o[b];
    endsequence

    trig_pulse_a: assert property (trig_wr(6) |=> one_pulse(6))
        else $error("trigger not one pulse");
    ep3_commit_a: assert property (trig_wr(6) ##1 !flush_o[6]
        |=> st_ff.dpres[5])
        else $error("ep3 not committed");
    ep0_commit_a: assert property (trig_wr(0) ##1 !flush_o[0]
        |=> st_ff.dpres[0])
        else $error("ep0 in not committed");
    ep3_nak_a: assert property (evt_i.ep3_in_token &&
        !st_ff.dpres[5] |=> ep3_nak_o && flags1[2])
        else $error("ep3 nak missing");
    halt_clear_a: assert property (evt_i.cmd_decoded |=> !halt_o[0])
        else $error("ep0 halt not cleared");
    halt_block_a: assert property (wr &&
        usb_ep_pkg::reg_hit(wb_i.adr, usb_ep_pkg::IDX_HALT) &&
        flags0[3] && !halt_o[0] |=> !halt_o[0])
        else $error("ep0 halt write not ignored");
    setup_gate_a: assert property (trig_o[2] && !evt_i.setup_rx
        |=> !data_stage_nak_o)
        else $error("data stage still held");
    irq_route_a: assert property ((pend_a != 8'h00)
        |=> usb_irq_line_a_o)
        else $error("line a not raised");
    vbus_edge_a: assert property ($rose(vbus_i) ##1 1'b1
        |-> flags1[0])
        else $error("connect flag missing");
    ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    sent_flag_a: assert property (evt_i.ep3_tx_acked |=> flags1[1])
        else $error("ep3 sent flag missing");
    line_b_route_a: assert property ((pend_b != 8'h00)
        |=> usb_irq_line_b_o)
        else $error("line b not raised");
    ep2_commit_a: assert property (trig_o[4] && !evt_i.ep2_tx_done &&
        !flush_o[4] |=> st_ff.dpres[4])
        else $error("ep2 not committed");
    size0_load_a: assert property (evt_i.ep0o_rx_done &&
        !flush_o[1] |=> st_ff.sz0 == $past(evt_i.rx_count))
        else $error("ep0 out size not loaded");
    flush_present_a: assert property (flush_o[6] |=> !st_ff.dpres[5])
        else $error("ep3 data survived clear");
    sent_clear_a: assert property (evt_i.ep3_tx_acked &&
        !trig_o[6] |=> !st_ff.dpres[5])
        else $error("ep3 present not cleared");
    pulse_clear_a: assert property (!wr
        |=> trig_o == 8'h00 && flush_o == 8'h00)
        else $error("trigger or clear stored");
    reserved_zero_a: assert property (
        (trig_o & ~usb_ep_pkg::TRIG_MASK) == 8'h00 &&
        (flush_o & ~usb_ep_pkg::CLEAR_MASK) == 8'h00)
        else $error("reserved pulse bit set");

endmodule
`default_nettype wire

/* File: verification/usb_host_model.sv */
// Host-side event source for the far end of the endpoint link
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
    input  wire logic                 clk_i,
    input  wire logic [3:0]           cmd_i,  // 0 idle, n picks event n
    input  wire logic [7:0]           cnt_i,  // Byte count to report
    output var  usb_ep_pkg::usb_evt_t evt_o
);
    // ****************
    // Event pulses
    // ****************
    // Count rides with every pulse, so it is valid with the done strobe
    always_ff @(posedge clk_i) begin
        evt_o <= '0;
        if (cmd_i != 4'h0) begin
            evt_o <= {8'h80 >> (cmd_i - 4'h1), cnt_i};
        end
    end
endmodule
`default_nettype wire

/* File: verification/usb_ep_ctrl_bench.sv */
// Self-checking bench for the endpoint control register block
`timescale 1ns/100ps
`default_nettype none
module usb_ep_ctrl_bench;
    // ****************
    // Signals
    // ****************
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    usb_ep_pkg::wb_req_t  req = '0;
    usb_ep_pkg::usb_evt_t evt;
    logic [31:0]          dat;
    logic                 ack, ia, ib, nak, dsn, vbus = 1'b0, nseen = 1'b0;
    logic [7:0]           f0 = 8'h00, cnt = 8'h00, trg, fl, rdat;
    logic [7:0]           tseen = 8'h00, fseen = 8'h00;  // Pulse history
    logic [3:0]           halt, cmd = 4'h0;
    int                   err_count = 0, compares = 0;

    always #2 clk_i = ~clk_i;
    // Pulses last one cycle, so collect them instead of racing them
    always @(posedge clk_i) begin
        if (!rst_i) begin
            tseen <= tseen | trg;
            fseen <= fseen | fl;
            nseen <= nseen | nak;
        end
    end

    usb_ep_ctrl i_usb_ep_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req),
        .wb_dat_o(dat), .wb_ack_o(ack), .evt_i(evt),
        .interrupt_flags_bank0_i(f0), .vbus_i(vbus), .trig_o(trg),
        .flush_o(fl), .halt_o(halt), .ep3_nak_o(nak),
        .data_stage_nak_o(dsn), .usb_irq_line_a_o(ia),
        .usb_irq_line_b_o(ib));
    usb_host_model i_usb_host_model (.clk_i(clk_i), .cmd_i(cmd),
        .cnt_i(cnt), .evt_o(evt));

    // ****************
    // Tasks
    // ****************
    task automatic ck(input logic [7:0] e, input logic [7:0] g,
                      input string n);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
        req <= {1'b1, 1'b1, w, a, 4'h1, 24'h000000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat[7:0];
        req <= '0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        ck(e, rdat, $sformatf("reg %h", a));
    endtask
    task automatic w3;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic ev(input logic [3:0] c, input logic [7:0] n);
        cmd <= c;
        cnt <= n;
        @(posedge clk_i);
        cmd <= 4'h0;
        w3;
    endtask
    task automatic print_verdict;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************
    // Tests
    // ****************
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'hC0, 8'h07);
        rd(8'h90, 8'h00);
        wb(1'b1, 8'h70, 8'h17);
        rd(8'h88, 8'h11);
        vbus <= 1'b1;
        w3;
        rd(8'h68, 8'h01);
        ck(8'h00, {7'h00, ib}, "irq_b");
        wb(1'b1, 8'hA0, 8'h01);
        w3;
        ck(8'h01, {7'h00, ib}, "irq_b");
        wb(1'b1, 8'hC0, 8'h00);
        w3;
        ck(8'h01, {7'h00, ia}, "irq_a");
        wb(1'b1, 8'h68, 8'hFE);
        rd(8'h68, 8'h00);
        ev(4'h1, 8'h00);
        rd(8'h68, 8'h04);
        ck(8'h01, {7'h00, nseen}, "ep3_nak");
        wb(1'b1, 8'h70, 8'h40);
        rd(8'h88, 8'h31);
        rd(8'h70, 8'h00);
        ev(4'h2, 8'h00);
        rd(8'h88, 8'h11);
        rd(8'h68, 8'h06);
        wb(1'b1, 8'h78, 8'h73);
        rd(8'h88, 8'h00);
        rd(8'h68, 8'h06);
        ck(8'h73, fseen, "flush_o");
        ev(4'h7, 8'h05);
        rd(8'h80, 8'h05);
        ev(4'h8, 8'h11);
        ev(4'h8, 8'h22);
        rd(8'hA8, 8'h11);
        wb(1'b1, 8'h70, 8'h20);
        rd(8'hA8, 8'h22);
        ck(8'h77, tseen, "trig_o");
        ev(4'h5, 8'h00);
        ck(8'h01, {7'h00, dsn}, "data_nak");
        wb(1'b1, 8'h70, 8'h04);
        w3;
        ck(8'h00, {7'h00, dsn}, "data_nak");
        wb(1'b1, 8'h90, 8'h0F);
        w3;
        ck(8'h0F, {4'h0, halt}, "halt_o");
        ev(4'h6, 8'h00);
        rd(8'h90, 8'h0E);
        f0 <= 8'h08;
        wb(1'b1, 8'h90, 8'h0F);
        rd(8'h90, 8'h0E);
        ck(8'h00, {7'h00, ia}, "irq_a");
        wb(1'b1, 8'h98, 8'h08);
        w3;
        ck(8'h01, {7'h00, ia}, "irq_a");
        wb(1'b1, 8'h70, 8'h11);
        wb(1'b1, 8'h70, 8'h10);
        wb(1'b1, 8'h70, 8'h10);  // third commit refused
        ev(4'h4, 8'h00);
        ev(4'h3, 8'h00);
        rd(8'h88, 8'h10);
        ev(4'h3, 8'h00);
        rd(8'h88, 8'h00);
        print_verdict;
    end
    // Watchdog well past the fewer than two hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk_i);
        err_count++;
        print_verdict;
    end
endmodule
`default_nettype wire
